// *** bench/enable_peer_model.sv ***
// Cascaded controller sharing the open-drain enable pins
`default_nettype none
module enable_peer_model (
  // Clock
  input  wire logic       clk_in,
  // Pull-downs on the shared pins
  input  wire logic [1:0] dut_oe_in,
  input  wire logic [1:0] peer_pull_in,
  // Wired level and the peer's own state
  output logic [1:0]      pin_level_out,
  output logic [1:0]      peer_off_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Resistor pull-up, so any party pulling low wins; nobody drives high
  assign pin_level_out = ~(dut_oe_in | peer_pull_in);
  // Peer stops switching once its pin reads low
  always_ff @(posedge clk_in) begin
    peer_off_out <= ~pin_level_out;
  end
endmodule // enable_peer_model
`default_nettype wire

// *** bench/seq_properties.sv ***
// Port-level assertions for the start-up phase sequencer, bound to its top module
`default_nettype none
module seq_checker (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // Watched inputs
  input wire logic        fault_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  // Watched outputs
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  enable_feedforward_pin_out,
  input wire logic [1:0]  enable_feedforward_pin_oe_out,
  input wire logic [1:0]  en_sink_on_out,
  input wire logic [1:0]  high_side_gate_en_out,
  input wire logic [1:0]  low_side_gate_en_out,
  input wire logic [1:0]  ss_done_out,
  input wire logic [10:0] ss_code1_out,
  input wire logic [8:0]  channel_phase_offset_out,
  input wire logic        ddr_mode_out,
  input wire logic        two_phase_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Fault long enough to clear the input synchronisers
  sequence fault_held;
    fault_in [*5];
  endsequence
  // Bus request seen while the slave still waits
  sequence bus_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  gate_off_fault_a: assert property ($rose(fault_in) |-> ##[1:10]
    (high_side_gate_en_out == 2'h0 && low_side_gate_en_out == 2'h0)) else $error("gates stay on");
  fault_pull_en_a: assert property (fault_held |-> enable_feedforward_pin_oe_out == 2'h3)
    else $error("enable pins not pulled low on fault");
  pin_drive_low_a: assert property (enable_feedforward_pin_out == 2'h0)
    else $error("enable pin driven high");
  ls_after_hs_a: assert property ($rose(low_side_gate_en_out[0]) |->
    $past(high_side_gate_en_out[0])) else $error("low side before high side");
  sink_off_run_a: assert property ($rose(high_side_gate_en_out[0]) |->
    en_sink_on_out == 2'h0) else $error("sink current on while switching");
  ss_step_a: assert property (ss_code1_out != $past(ss_code1_out) && ss_code1_out != 11'h0
    |-> ss_code1_out == $past(ss_code1_out) + 11'h1) else $error("soft-start skipped a step");
  ss_done_full_a: assert property ($rose(ss_done_out[0]) |->
    ss_code1_out == seq_pkg::SS_LAST) else $error("soft-start done early");
  ddr_lead_a: assert property (ddr_mode_out |->
    channel_phase_offset_out == seq_pkg::PH_M60) else $error("tracking offset wrong");
  two_phase_a: assert property (two_phase_out |->
    channel_phase_offset_out == seq_pkg::PH_180) else $error("two-phase offset wrong");
  bus_answer_a: assert property (bus_req |=> !avs_waitrequest_out)
    else $error("bus answer late");
  bus_one_cycle_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
endmodule // seq_checker
bind buck_startup_phase_sequencer seq_checker chk_u (.clk_in, .sys_rst_in, .fault_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .enable_feedforward_pin_out,
  .enable_feedforward_pin_oe_out, .en_sink_on_out, .high_side_gate_en_out,
  .low_side_gate_en_out, .ss_done_out, .ss_code1_out, .channel_phase_offset_out,
  .ddr_mode_out, .two_phase_out);
`default_nettype wire

// *** bench/test_buck_startup_phase_sequencer.sv ***
// Self-checking bench for the start-up phase sequencer
`default_nettype none
module test_buck_startup_phase_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK  = 4;     // Clock cycles per phase tick
  localparam int LIMIT = 30000; // Two bring-ups fit well inside
  logic        clk_in, sys_rst_in, driver_supply_ok_in, bias_supply_ok_in, pll_locked_in;
  logic        phase_clock_in, fault_in, ch2_negative_sense_in, ch2_feedback_in;
  logic        avs_read_in, avs_write_in, avs_waitrequest_out, ddr_mode_out, two_phase_out;
  logic [1:0]  enable_feedforward_pin_in, enable_feedforward_pin_out, peer_pull, peer_off;
  logic [1:0]  enable_feedforward_pin_oe_out, en_sink_on_out, out_above_tgt_in;
  logic [1:0]  out_above_113_in, out_above_120_in, out_below_87_in, out_below_uv_in;
  logic [1:0]  high_side_gate_en_out, low_side_gate_en_out, low_side_gate_force_out, ss_done_out;
  logic [2:0]  clock_out_ref_in_pin_in;
  logic [3:0]  avs_address_in;
  logic [8:0]  channel_phase_offset_out;
  logic [10:0] ss_code1_out, ss_code2_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  int          err_total, tests_run, cyc = 0;
  // Design under test
  buck_startup_phase_sequencer dut_u (.clk_in, .sys_rst_in, .driver_supply_ok_in,
    .bias_supply_ok_in, .pll_locked_in, .phase_clock_in, .fault_in, .enable_feedforward_pin_in,
    .enable_feedforward_pin_out, .enable_feedforward_pin_oe_out, .en_sink_on_out,
    .ch2_negative_sense_in, .ch2_feedback_in, .clock_out_ref_in_pin_in, .out_above_tgt_in,
    .out_above_113_in, .out_above_120_in, .out_below_87_in, .out_below_uv_in,
    .high_side_gate_en_out, .low_side_gate_en_out, .low_side_gate_force_out, .ss_done_out,
    .ss_code1_out, .ss_code2_out, .channel_phase_offset_out, .ddr_mode_out, .two_phase_out,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out);
  // Far side: other controllers on the enable pins
  enable_peer_model peer_u (.clk_in, .dut_oe_in(enable_feedforward_pin_oe_out),
    .peer_pull_in(peer_pull), .pin_level_out(enable_feedforward_pin_in), .peer_off_out(peer_off));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Phase clock at a quarter rate and the hang watchdog
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    phase_clock_in <= cyc[1];
    if (cyc == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One bus cycle; read data lands in rd
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask
  // Cycles until both channels lose their gate permits
  task automatic gates_off;
    int n;
    n = 0;
    while ((high_side_gate_en_out | low_side_gate_en_out) !== 2'h0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    chk(n <= seq_pkg::GATE_OFF_CYC, 1);
  endtask
  task automatic t_reset;
    chk(en_sink_on_out, 2'h3);
    chk({high_side_gate_en_out, low_side_gate_en_out, ss_code1_out}, 0);
    step(4);
    bus(1'b0, seq_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h00b4_0100);
    bus(1'b1, seq_pkg::REG_STATUS, 32'hffff_ffff);
    bus(1'b0, seq_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h00b4_0100);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h3);
    bus(1'b0, seq_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h3);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h0);
    $display("t_reset finished");
  endtask
  task automatic t_modes;
    logic [4:0] strap [5] = '{5'b01111, 5'b01011, 5'b01001, 5'b01000, 5'b10000};
    logic [8:0] off [5] = '{seq_pkg::PH_180, seq_pkg::PH_90, seq_pkg::PH_0, seq_pkg::PH_M60,
                            seq_pkg::PH_180};
    for (int i = 0; i < 5; i++) begin
      {ch2_negative_sense_in, ch2_feedback_in, clock_out_ref_in_pin_in} <= strap[i];
      step(6);
      chk(channel_phase_offset_out, off[i]);
      chk({ddr_mode_out, two_phase_out}, {i == 3, i == 4});
    end
    {ch2_negative_sense_in, ch2_feedback_in, clock_out_ref_in_pin_in} <= 5'b01111;
    $display("t_modes finished");
  endtask
  // Pre-charge above 113% and 120% with enable held low
  task automatic t_pre;
    out_above_113_in <= 2'h1;
    step(6);
    chk({low_side_gate_force_out, enable_feedforward_pin_oe_out}, 4'h7);
    out_above_113_in <= 2'h0;
    out_below_87_in  <= 2'h1;
    step(6);
    chk(low_side_gate_force_out, 2'h0);
    out_below_87_in  <= 2'h0;
    out_above_120_in <= 2'h1;
    step(6);
    out_above_120_in <= 2'h0;
    peer_pull        <= 2'h0;
    step(20);
    bus(1'b0, seq_pkg::REG_STATUS, 32'h0);
    chk(rd[12:8], 5'h10);
    chk({enable_feedforward_pin_oe_out, ss_code1_out}, 13'h1800);
    peer_pull         <= 2'h3;
    bias_supply_ok_in <= 1'b0;
    step(6);
    bias_supply_ok_in <= 1'b1;
    step(6);
    bus(1'b0, seq_pkg::REG_STATUS, 32'h0);
    chk(rd[12:8], 5'h01);
    $display("t_pre finished");
  endtask
  // Full start: channel 1 plain, channel 2 pre-charged above target
  task automatic t_start;
    int n;
    out_above_tgt_in <= 2'h2;
    peer_pull        <= 2'h0;
    step(100);
    chk({en_sink_on_out, high_side_gate_en_out}, 4'h0);
    n = 100;
    while (ss_code1_out === 11'h0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    chk(n >= 384 * TICK && n <= 386 * TICK + 8, 1);
    out_below_uv_in <= 2'h1;
    step(20);
    chk(low_side_gate_en_out[0], 1'b1);
    out_below_uv_in <= 2'h0;
    n = 20;
    while (ss_done_out !== 2'h3 && n < 6000) begin
      @(posedge clk_in);
      n++;
    end
    chk(n >= 1279 * TICK - 4 && n <= 1279 * TICK + 8, 1);
    chk({ss_code1_out, ss_code2_out}, {seq_pkg::SS_LAST, seq_pkg::SS_LAST});
    step(12);
    chk({high_side_gate_en_out, low_side_gate_en_out}, 4'h5);
    out_above_tgt_in <= 2'h0;
    step(12);
    chk({high_side_gate_en_out, low_side_gate_en_out}, 4'hf);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h2);
    clock_out_ref_in_pin_in <= 3'h3;
    step(6);
    chk(channel_phase_offset_out, seq_pkg::PH_180);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h0);
    out_below_uv_in <= 2'h1;
    step(6);
    chk({high_side_gate_en_out, low_side_gate_en_out}, 4'he);
    out_below_uv_in <= 2'h0;
    $display("t_start finished");
  endtask
  task automatic t_fault;
    fault_in <= 1'b1;
    gates_off();
    step(4);
    chk({enable_feedforward_pin_oe_out, peer_off, ss_code1_out}, 15'h7800);
    fault_in <= 1'b0;
    step(8);
    chk(enable_feedforward_pin_oe_out, 2'h0);
    $display("t_fault finished");
  endtask
  // Peer pulls the shared pins low while both channels run
  task automatic t_peer;
    int n;
    n = 0;
    while (ss_done_out !== 2'h3 && n < 8000) begin
      @(posedge clk_in);
      n++;
    end
    step(12);
    chk(high_side_gate_en_out, 2'h3);
    peer_pull <= 2'h3;
    gates_off();
    step(4);
    chk({ss_code1_out, ss_code2_out}, 0);
    peer_pull <= 2'h0;
    step(200);
    chk(ss_code1_out, 11'h0);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h1);
    step(4);
    bus(1'b0, seq_pkg::REG_STATUS, 32'h0);
    chk({rd[12:8], en_sink_on_out}, 7'h07);
    bus(1'b1, seq_pkg::REG_CTRL, 32'h0);
    $display("t_peer finished");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence; enable starts gated low by the peer's open drain
  initial begin
    {err_total, tests_run} = '0;
    {fault_in, avs_read_in, avs_write_in, ch2_negative_sense_in} = '0;
    {sys_rst_in, driver_supply_ok_in, bias_supply_ok_in, pll_locked_in, ch2_feedback_in} = '1;
    {out_above_tgt_in, out_above_113_in, out_above_120_in, out_below_87_in} = '0;
    out_below_uv_in         = 2'h0;
    clock_out_ref_in_pin_in = 3'h7;
    avs_address_in          = 4'h0;
    avs_writedata_in        = 32'h0;
    peer_pull               = 2'h3;
    step(5);
    sys_rst_in <= 1'b0;
    step(1);
    t_reset();
    t_modes();
    t_pre();
    t_start();
    t_fault();
    t_peer();
    print_verdict();
  end
endmodule // test_buck_startup_phase_sequencer
`default_nettype wire

// *** design/buck_startup_phase_sequencer.sv ***
// Start-up, soft-start, latch-off and phase sequencing for a dual buck controller
`default_nettype none
module buck_startup_phase_sequencer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Supply, lock and fault levels from the analog side
  input  wire logic        driver_supply_ok_in,
  input  wire logic        bias_supply_ok_in,
  input  wire logic        pll_locked_in,
  input  wire logic        phase_clock_in,
  input  wire logic        fault_in,
  // Shared enable pins, one per channel, open drain
  input  wire logic [1:0]  enable_feedforward_pin_in,
  output logic [1:0]       enable_feedforward_pin_out,
  output logic [1:0]       enable_feedforward_pin_oe_out,
  output logic [1:0]       en_sink_on_out,
  // Mode straps
  input  wire logic        ch2_negative_sense_in,
  input  wire logic        ch2_feedback_in,
  input  wire logic [2:0]  clock_out_ref_in_pin_in,
  // Output comparators, bit 0 channel 1
  input  wire logic [1:0]  out_above_tgt_in,
  input  wire logic [1:0]  out_above_113_in,
  input  wire logic [1:0]  out_above_120_in,
  input  wire logic [1:0]  out_below_87_in,
  input  wire logic [1:0]  out_below_uv_in,
  // Gate permits and soft-start status
  output logic [1:0]       high_side_gate_en_out,
  output logic [1:0]       low_side_gate_en_out,
  output logic [1:0]       low_side_gate_force_out,
  output logic [1:0]       ss_done_out,
  output logic [10:0]      ss_code1_out,
  output logic [10:0]      ss_code2_out,
  // Phase relationship
  output logic [8:0]       channel_phase_offset_out,
  output logic             ddr_mode_out,
  output logic             two_phase_out,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);
  localparam int SYNC_W = 22;

  logic [SYNC_W-1:0]   sync1_q;
  logic [SYNC_W-1:0]   sync2_q;
  logic                ph_prev_q;
  logic                tick;
  logic                drv_ok;
  logic                bias_ok;
  logic                pll_ok;
  logic                ph_lvl;
  logic                flt;
  logic [1:0]          en_ok;
  logic                neg_hi;
  logic                fb_hi;
  logic [2:0]          ref_lvl;
  logic [1:0]          c_tgt;
  logic [1:0]          c_113;
  logic [1:0]          c_120;
  logic [1:0]          c_87;
  logic [1:0]          c_uv;
  seq_pkg::seq_state_t state_q;
  seq_pkg::seq_state_t state_d;
  logic [8:0]          dly_q;
  logic                dly_done;
  logic                qual;
  logic                ramping;
  logic                arming;
  logic [1:0]          run_ch;
  logic [1:0]          hiccup;
  logic [1:0]          ov_req;
  logic                ov_any;
  logic                all_done;
  logic [1:0]          ctrl_q;
  logic                wait_q;

  // Every pin level crosses two flops before any logic looks at it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {driver_supply_ok_in, bias_supply_ok_in, pll_locked_in,
                  phase_clock_in, fault_in, enable_feedforward_pin_in,
                  ch2_negative_sense_in, ch2_feedback_in,
                  clock_out_ref_in_pin_in, out_above_tgt_in,
                  out_above_113_in, out_above_120_in, out_below_87_in,
                  out_below_uv_in};
      sync2_q <= sync1_q;
    end
  end

  // Named views of the synchronised levels
  assign {drv_ok, bias_ok, pll_ok, ph_lvl, flt, en_ok, neg_hi, fb_hi,
          ref_lvl, c_tgt, c_113, c_120, c_87, c_uv} = sync2_q;

  // Phase clock edge detect, taken from the second stage only
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ph_prev_q <= 1'b0;
    end else begin
      ph_prev_q <= ph_lvl;
    end
  end
  assign tick = ph_lvl && !ph_prev_q;

  // Power-on qualification; the enable term drops it only once both enable pins read low
  assign qual = drv_ok && bias_ok && pll_ok && (|en_ok) && !flt
                && !ctrl_q[seq_pkg::CTRL_SHDN];
  assign ov_any   = |ov_req;
  assign dly_done = tick && dly_q == seq_pkg::DELAY_LAST;
  // An unused channel counts as finished
  assign all_done = &(ss_done_out | ~en_ok);

  // Sequencer next state; latch request overrides qualification in the off, delay and soft-start states
  always_comb begin
    state_d = state_q;
    case (state_q)
      seq_pkg::ST_OFF: begin
        if (ov_any) begin
          state_d = seq_pkg::ST_LATCH;
        end else if (qual) begin
          state_d = seq_pkg::ST_DELAY;
        end
      end
      seq_pkg::ST_DELAY: begin
        if (ov_any) begin
          state_d = seq_pkg::ST_LATCH;
        end else if (!qual) begin
          state_d = seq_pkg::ST_OFF;
        end else if (dly_done) begin
          state_d = seq_pkg::ST_SOFT;
        end
      end
      seq_pkg::ST_SOFT: begin
        if (ov_any) begin
          state_d = seq_pkg::ST_LATCH;
        end else if (!qual) begin
          state_d = seq_pkg::ST_OFF;
        end else if (all_done) begin
          state_d = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (!qual) begin
          state_d = seq_pkg::ST_OFF;
        end
      end
      seq_pkg::ST_LATCH: begin
        if (!bias_ok) begin
          state_d = seq_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = seq_pkg::ST_OFF;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= seq_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up delay in phase clock cycles; only counts while waiting
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state_q != seq_pkg::ST_DELAY) begin
      dly_q <= 9'h000;
    end else if (tick) begin
      dly_q <= dly_q + 9'h001;
    end
  end

  // Channel run and arm terms
  assign ramping = (state_q == seq_pkg::ST_SOFT) || (state_q == seq_pkg::ST_RUN);
  assign arming  = ((state_q == seq_pkg::ST_OFF) || (state_q == seq_pkg::ST_DELAY))
                   && drv_ok && bias_ok;
  assign run_ch  = {2{ramping}} & en_ok;

  // Channel 1 soft-start
  soft_start_channel u_ch1 (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (run_ch[0]),
    .arm_in       (arming),
    .tick_in      (tick),
    .above_tgt_in (c_tgt[0]),
    .above_113_in (c_113[0]),
    .above_120_in (c_120[0]),
    .below_87_in  (c_87[0]),
    .below_uv_in  (c_uv[0]),
    .ss_code_out  (ss_code1_out),
    .ss_done_out  (ss_done_out[0]),
    .hs_en_out    (high_side_gate_en_out[0]),
    .ls_en_out    (low_side_gate_en_out[0]),
    .ls_force_out (low_side_gate_force_out[0]),
    .hiccup_out   (hiccup[0]),
    .ov_latch_out (ov_req[0])
  );

  // Channel 2 soft-start; own comparators and ramp, but a latch request from either channel stops both
  soft_start_channel u_ch2 (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (run_ch[1]),
    .arm_in       (arming),
    .tick_in      (tick),
    .above_tgt_in (c_tgt[1]),
    .above_113_in (c_113[1]),
    .above_120_in (c_120[1]),
    .below_87_in  (c_87[1]),
    .below_uv_in  (c_uv[1]),
    .ss_code_out  (ss_code2_out),
    .ss_done_out  (ss_done_out[1]),
    .hs_en_out    (high_side_gate_en_out[1]),
    .ls_en_out    (low_side_gate_en_out[1]),
    .ls_force_out (low_side_gate_force_out[1]),
    .hiccup_out   (hiccup[1]),
    .ov_latch_out (ov_req[1])
  );

  // Enable pins: pulled low on fault, latch-off or hiccup; never driven high
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_feedforward_pin_out    <= 2'h0;
      enable_feedforward_pin_oe_out <= 2'h0;
    end else begin
      enable_feedforward_pin_out    <= 2'h0;
      enable_feedforward_pin_oe_out <= {2{flt || state_q == seq_pkg::ST_LATCH
                                          || (|hiccup)}};
    end
  end

  // Hysteresis sink stays on while the sequencer is in the off or latch-off state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_sink_on_out <= 2'h3;
    end else begin
      en_sink_on_out <= {2{state_q == seq_pkg::ST_OFF
                           || state_q == seq_pkg::ST_LATCH}};
    end
  end

  // Phase decode from straps; a freeze keeps the start-up choice while running
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      channel_phase_offset_out <= seq_pkg::PH_0;
      ddr_mode_out             <= 1'b0;
      two_phase_out            <= 1'b0;
    end else if (!(ctrl_q[seq_pkg::CTRL_FREEZE] && ramping)) begin
      if (neg_hi) begin
        channel_phase_offset_out <= seq_pkg::PH_180;
        ddr_mode_out             <= 1'b0;
        two_phase_out            <= !fb_hi;
      end else begin
        two_phase_out <= 1'b0;
        ddr_mode_out  <= !ref_lvl[0];
        if (ref_lvl[2]) begin
          channel_phase_offset_out <= seq_pkg::PH_180;
        end else if (ref_lvl[1]) begin
          channel_phase_offset_out <= seq_pkg::PH_90;
        end else if (ref_lvl[0]) begin
          channel_phase_offset_out <= seq_pkg::PH_0;
        end else begin
          channel_phase_offset_out <= seq_pkg::PH_M60;
        end
      end
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign avs_waitrequest_out = wait_q;

  // Control register; writes land on the edge that sees waitrequest low
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= seq_pkg::CTRL_RESET;
    end else if (avs_write_in && !wait_q && avs_address_in == seq_pkg::REG_CTRL) begin
      ctrl_q <= avs_writedata_in[1:0];
    end
  end

  // Read data captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && wait_q) begin
      case (avs_address_in)
        seq_pkg::REG_CTRL:   avs_readdata_out <= {30'h0, ctrl_q};
        seq_pkg::REG_STATUS: avs_readdata_out <= {7'h0, channel_phase_offset_out,
                                                  3'h0, state_q, two_phase_out,
                                                  ddr_mode_out, hiccup, ov_req,
                                                  ss_done_out};
        seq_pkg::REG_SS1:    avs_readdata_out <= {21'h0, ss_code1_out};
        seq_pkg::REG_SS2:    avs_readdata_out <= {21'h0, ss_code2_out};
        default:             avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end
endmodule // buck_startup_phase_sequencer
`default_nettype wire

// *** design/seq_pkg.sv ***
// Shared constants and types for the buck start-up phase sequencer
`default_nettype none
package seq_pkg;
  // Start-up delay in phase clock cycles
  localparam int          DELAY_CYC  = 384;
  localparam logic [8:0]  DELAY_LAST = 9'(DELAY_CYC - 1);
  // Full soft-start ramp in switching cycles
  localparam int          SS_STEPS   = 1280;
  localparam logic [10:0] SS_LAST    = 11'(SS_STEPS);
  // Gate response budget on shutdown
  localparam int          CLK_NS      = 10;
  localparam int          GATE_OFF_NS = 100;
  localparam int          GATE_OFF_CYC = GATE_OFF_NS / CLK_NS;
  // Register byte offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_SS1    = 4'h8;
  localparam logic [3:0]  REG_SS2    = 4'hc;
  // Control fields
  localparam int          CTRL_SHDN   = 0;
  localparam int          CTRL_FREEZE = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  // Phase offsets of channel 2 against channel 1, degrees, negative is a lead
  localparam logic [8:0]  PH_0    = 9'h000;
  localparam logic [8:0]  PH_90   = 9'h05a;
  localparam logic [8:0]  PH_180  = 9'h0b4;
  localparam logic [8:0]  PH_M60  = 9'h1c4;
  // Sequencer states
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_DELAY = 5'h02,
    ST_SOFT  = 5'h04,
    ST_RUN   = 5'h08,
    ST_LATCH = 5'h10
  } seq_state_t;
endpackage
`default_nettype wire

// *** design/soft_start_channel.sv ***
// One channel's digital soft-start and pre-charged start-up handling
`default_nettype none
module soft_start_channel (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Sequencer control
  input  wire logic        run_in,
  input  wire logic        arm_in,
  input  wire logic        tick_in,
  // Output voltage comparators
  input  wire logic        above_tgt_in,
  input  wire logic        above_113_in,
  input  wire logic        above_120_in,
  input  wire logic        below_87_in,
  input  wire logic        below_uv_in,
  // Status and gate permits
  output logic [10:0]      ss_code_out,
  output logic             ss_done_out,
  output logic             hs_en_out,
  output logic             ls_en_out,
  output logic             ls_force_out,
  output logic             hiccup_out,
  output logic             ov_latch_out
);
  logic pre_hi_q;
  logic first_pulse_q;

  // Reference counter, one step per phase clock pulse, cleared when not running
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      ss_code_out <= 11'h000;
    end else if (tick_in && ss_code_out != seq_pkg::SS_LAST) begin
      ss_code_out <= ss_code_out + 11'h001;
    end
  end

  // Done also opens undervoltage detection
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ss_done_out <= 1'b0;
    end else begin
      ss_done_out <= run_in && ss_code_out == seq_pkg::SS_LAST;
    end
  end

  // Pre-charged above target: hold switching until ramp done and output at target
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre_hi_q <= 1'b0;
    end else if (!run_in) begin
      pre_hi_q <= above_tgt_in;
    end else if (ss_done_out && !above_tgt_in) begin
      pre_hi_q <= 1'b0;
    end
  end

  // First high-side pulse seen since start
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      first_pulse_q <= 1'b0;
    end else if (hs_en_out && tick_in) begin
      first_pulse_q <= 1'b1;
    end
  end

  // Gate permits; low side waits for a real pulse so a pre-bias is not pulled down
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hs_en_out <= 1'b0;
      ls_en_out <= 1'b0;
    end else begin
      hs_en_out <= run_in && !pre_hi_q && !ov_latch_out;
      ls_en_out <= run_in && hs_en_out && first_pulse_q
                   && !(ss_done_out && below_uv_in);
    end
  end

  // Pre-charge between 113 and 120 percent: hiccup with enable held low
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hiccup_out <= 1'b0;
    end else if (arm_in && !run_in && above_113_in && !above_120_in) begin
      hiccup_out <= 1'b1;
    end else if (below_87_in) begin
      hiccup_out <= 1'b0;
    end
  end

  // Low side on at 113 percent, off at 87 percent
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ls_force_out <= 1'b0;
    end else if (hiccup_out && above_113_in) begin
      ls_force_out <= 1'b1;
    end else if (below_87_in) begin
      ls_force_out <= 1'b0;
    end
  end

  // Over 120 percent before or during the ramp asks for latch-off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ov_latch_out <= 1'b0;
    end else if ((arm_in || run_in) && !ss_done_out && above_120_in) begin
      ov_latch_out <= 1'b1;
    end else if (!arm_in && !run_in) begin
      ov_latch_out <= 1'b0;
    end
  end
endmodule // soft_start_channel
`default_nettype wire
